// ---- include/speed_select_pkg.sv ----
// constants, field layout and types shared by the speed command select block
package speed_select_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_PRESETS = 15;
  localparam int NUM_TERMS = 5;

  localparam logic [7:0] ADDR_PRESET_BASE = 8'h00;
  localparam logic [7:0] ADDR_JOG_FREQ    = 8'h10;
  localparam logic [7:0] ADDR_JOG_RAMP    = 8'h11;
  localparam logic [7:0] ADDR_ACCEL_REF   = 8'h12;
  localparam logic [7:0] ADDR_BOOST       = 8'h13;
  localparam logic [7:0] ADDR_BOOST2      = 8'h14;
  localparam logic [7:0] ADDR_CONTROL     = 8'h15;
  localparam logic [7:0] ADDR_TERM_BASE   = 8'h18;
  localparam logic [7:0] ADDR_STATUS      = 8'h20;
  localparam logic [7:0] ADDR_FREQ_CMD    = 8'h21;
  localparam logic [7:0] ADDR_RUN_FREQ    = 8'h22;

  // ----------------------------------------------------------------
  // values after reset (frequency in 0.1 Hz, time in 0.1 s, boost in 0.1 %)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_HIGH_FREQ  = 16'h01f4;
  localparam logic [15:0] RST_MID_FREQ   = 16'h012c;
  localparam logic [15:0] RST_LOW_FREQ   = 16'h0064;
  localparam logic [15:0] NOT_SELECTED   = 16'h270f;
  localparam logic [15:0] FREQ_MAX       = 16'h0fa0;
  localparam logic [15:0] RST_JOG_FREQ   = 16'h0032;
  localparam logic [15:0] RST_JOG_RAMP   = 16'h0005;
  localparam logic [15:0] RAMP_MAX       = 16'h8ca0;
  localparam logic [15:0] RST_ACCEL_REF  = 16'h01f4;
  localparam logic [15:0] RST_BOOST      = 16'h003c;
  localparam logic [15:0] RST_BOOST2     = 16'h003c;
  localparam logic [15:0] RST_CONTROL    = 16'h0008;

  // control register fields
  localparam int CTL_PATTERN_LSB = 0;
  localparam int CTL_OPMODE_LSB  = 2;
  localparam int CTL_REMOTE_LSB  = 5;
  localparam int CTL_FLUX_BIT    = 7;

  // ----------------------------------------------------------------
  // terminal function codes, modes and sources
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_LOW    = 4'h0;
  localparam logic [3:0] FN_MID    = 4'h1;
  localparam logic [3:0] FN_HIGH   = 4'h2;
  localparam logic [3:0] FN_SECOND = 4'h3;
  localparam logic [3:0] FN_JOG    = 4'h5;
  localparam logic [3:0] FN_EXTRA  = 4'h8;
  localparam logic [NUM_TERMS-1:0][3:0] RST_TERM_FN = {FN_EXTRA, FN_JOG, FN_HIGH, FN_MID, FN_LOW};

  localparam logic [2:0] OPM_PANEL    = 3'h1;
  localparam logic [2:0] OPM_EXTERNAL = 3'h2;
  localparam logic [2:0] OPM_COMB_A   = 3'h3;
  localparam logic [2:0] OPM_COMB_B   = 3'h4;

  typedef enum logic [1:0] {
    PAT_CONST    = 2'b00,
    PAT_VARIABLE = 2'b01,
    PAT_LIFT_FWD = 2'b10,
    PAT_LIFT_REV = 2'b11
  } pattern_t;

  typedef enum logic [2:0] {
    SRC_NONE    = 3'b000,
    SRC_JOG     = 3'b001,
    SRC_PRESET  = 3'b010,
    SRC_CURRENT = 3'b011,
    SRC_VOLTAGE = 3'b100
  } source_t;

  // preset slot per {extra, high, middle, low}; slot 0 high, 1 middle, 2 low, 3..14 speed 4..15
  localparam logic [3:0] SLOT_NONE = 4'hf;
  localparam logic [3:0] SLOT_HIGH = 4'h0;
  localparam logic [3:0] SLOT_MID  = 4'h1;
  localparam logic [3:0] SLOT_LOW  = 4'h2;
  localparam logic [3:0] SEL_EXTRA_ONLY = 4'h8;
  localparam logic [15:0][3:0] SPEED_MAP = {4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7,
                                            4'h6, 4'h5, 4'h4, 4'h0, 4'h3, 4'h1, 4'h2, 4'hf};

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int RAMP_UNIT_NS = 100000000;
  localparam int TICKS_PER_RAMP_UNIT = RAMP_UNIT_NS / TICK_NS;

endpackage

// ---- verilog/pin_sync.sv ----
// three-stage synchroniser for pin inputs with agreement filter
module pin_sync
  import speed_select_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // s1 is only ever read by s2; a bit moves once s2 and s3 agree
  always_comb begin
    next_s    = s;
    next_s.s1 = i_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q  = (s.s2 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3));
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.q;

endmodule

// ---- verilog/freq_ramp.sv ----
// linear frequency ramp, one 0.1 Hz step at most per tick
module freq_ramp
  import speed_select_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_target,
  input  wire logic [15:0] i_ramp_time,
  input  wire logic [15:0] i_ref_freq,
  output logic      [15:0] o_freq
);

  typedef struct packed {
    logic [15:0] cur;
    logic [31:0] acc;
  } ramp_t;

  ramp_t s;
  ramp_t next_s;
  logic [31:0] span;
  logic [31:0] sum;

  // the ramp time spans zero to the reference frequency, so the slope is ref/span
  assign span = 32'(i_ramp_time) * 32'(TICKS_PER_RAMP_UNIT);
  assign sum  = s.acc + 32'(i_ref_freq);

  always_comb begin
    next_s = s;
    if (span == 32'h0000_0000 || i_ref_freq == 16'h0000) begin
      next_s.cur = i_target;
      next_s.acc = '0;
    end else if (i_tick) begin
      if (s.cur == i_target) begin
        next_s.acc = '0;
      end else if (sum >= span) begin
        // one common slope up and down
        next_s.cur = (s.cur < i_target) ? s.cur + 16'h0001 : s.cur - 16'h0001;
        next_s.acc = sum - span;
      end else begin
        next_s.acc = sum;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_freq = s.cur;

endmodule

// ---- verilog/contact_speed_command_select.sv ----
// running frequency command selection from contact inputs, with jog and boost direction
module contact_speed_command_select
  import speed_select_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [DATA_W-1:0]    i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [DATA_W-1:0]    o_rdata,
  // contact pins
  input  wire logic [NUM_TERMS-1:0] i_terminal,
  input  wire logic                 i_forward_start,
  input  wire logic                 i_reverse_start,
  // operation panel, same clock
  input  wire logic                 i_panel_jog_mode,
  input  wire logic                 i_panel_run,
  input  wire logic                 i_panel_reverse,
  // analog references, same clock, 0.1 Hz units
  input  wire logic                 i_current_ref_valid,
  input  wire logic [15:0]          i_current_ref,
  input  wire logic                 i_voltage_ref_valid,
  input  wire logic [15:0]          i_voltage_ref,
  // to frequency reference and voltage pattern logic
  output logic      [15:0]          o_freq_cmd,
  output logic      [15:0]          o_run_freq,
  output logic      [2:0]           o_source,
  output logic                      o_run,
  output logic                      o_reverse,
  output logic                      o_jog_mode,
  output logic      [15:0]          o_torque_boost
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PRESETS-1:0][15:0] preset;
    logic [15:0]                  jog_freq;
    logic [15:0]                  jog_ramp;
    logic [15:0]                  accel_ref;
    logic [15:0]                  boost;
    logic [15:0]                  boost2;
    logic [15:0]                  control;
    logic [NUM_TERMS-1:0][3:0]    term_fn;
    logic [15:0]                  rdata;
    logic [15:0]                  freq_cmd;
    source_t                      source;
    logic [3:0]                   slot;
    logic                         run;
    logic                         reverse;
    logic                         jog_mode;
    logic [15:0]                  torque_boost;
    logic [8:0]                   tick_cnt;
    logic                         tick;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // pin synchronisation and terminal routing
  // ----------------------------------------------------------------
  logic [NUM_TERMS+1:0]       pin_level;
  logic [NUM_TERMS-1:0][15:0] term_hit;
  logic [15:0]                fn_active;
  logic                       fwd;
  logic                       rev;

  pin_sync #(
    .W (NUM_TERMS + 2)
  ) u_pin_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     ({i_reverse_start, i_forward_start, i_terminal}),
    .o_level   (pin_level)
  );

  assign fwd = pin_level[NUM_TERMS];
  assign rev = pin_level[NUM_TERMS+1];

  // each terminal raises the function its code names; several terminals may share one
  genvar t;
  generate
    for (t = 0; t < NUM_TERMS; t = t + 1) begin : g_term
      assign term_hit[t] = pin_level[t] ? (16'h0001 << s.term_fn[t]) : 16'h0000;
    end
  endgenerate

  always_comb begin
    fn_active = 16'h0000;
    for (int k = 0; k < NUM_TERMS; k++) begin
      fn_active = fn_active | term_hit[k];
    end
  end

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic       sel_low;
  logic       sel_mid;
  logic       sel_high;
  logic       sel_extra;
  logic       sel_second;
  logic       sel_jog;
  logic [2:0] op_mode;
  logic [1:0] remote_sel;
  pattern_t   pattern;
  logic       flux_vector;

  assign sel_low     = fn_active[FN_LOW];
  assign sel_mid     = fn_active[FN_MID];
  assign sel_high    = fn_active[FN_HIGH];
  assign sel_extra   = fn_active[FN_EXTRA];
  assign sel_second  = fn_active[FN_SECOND];
  assign sel_jog     = fn_active[FN_JOG];
  assign op_mode     = s.control[CTL_OPMODE_LSB +: 3];
  assign remote_sel  = s.control[CTL_REMOTE_LSB +: 2];
  assign pattern     = pattern_t'(s.control[CTL_PATTERN_LSB +: 2]);
  assign flux_vector = s.control[CTL_FLUX_BIT];

  // ----------------------------------------------------------------
  // preset selection
  // ----------------------------------------------------------------
  logic       preset_allowed;
  logic [3:0] sel_code;
  logic [3:0] map_slot;
  logic [3:0] basic_slot;
  logic [3:0] preset_slot;

  // remote setting reuses the three basic selects, so presets stand aside
  assign preset_allowed = (op_mode == OPM_EXTERNAL || op_mode == OPM_COMB_A || op_mode == OPM_COMB_B)
                          && (remote_sel == 2'b00);
  assign sel_code = {sel_extra, sel_high, sel_mid, sel_low};
  assign map_slot = SPEED_MAP[sel_code];

  always_comb begin
    // lowest-ranked basic select wins when several are on
    if (sel_low) begin
      basic_slot = SLOT_LOW;
    end else if (sel_mid) begin
      basic_slot = SLOT_MID;
    end else if (sel_high) begin
      basic_slot = SLOT_HIGH;
    end else begin
      basic_slot = SLOT_NONE;
    end
    if (map_slot == SLOT_NONE) begin
      preset_slot = SLOT_NONE;
    end else if (s.preset[map_slot] != NOT_SELECTED) begin
      preset_slot = map_slot;
    end else if (sel_code == SEL_EXTRA_ONLY) begin
      preset_slot = SLOT_LOW;
    end else begin
      // an unset combination falls back to the basic priority
      preset_slot = basic_slot;
    end
  end

  // ----------------------------------------------------------------
  // run, jog and source priority
  // ----------------------------------------------------------------
  logic      panel;
  logic      jog_mode;
  logic      run;
  logic      reverse;
  source_t   source;
  logic [15:0] freq_sel;

  assign panel    = (op_mode == OPM_PANEL);
  assign jog_mode = panel ? i_panel_jog_mode : sel_jog;
  // both start inputs on together is treated as stop
  assign run      = panel ? i_panel_run : (fwd ^ rev);
  assign reverse  = panel ? i_panel_reverse : rev;

  always_comb begin
    if (jog_mode) begin
      source   = SRC_JOG;
      freq_sel = s.jog_freq;
    end else if (preset_allowed && preset_slot != SLOT_NONE) begin
      source   = SRC_PRESET;
      freq_sel = s.preset[preset_slot];
    end else if (i_current_ref_valid) begin
      source   = SRC_CURRENT;
      freq_sel = i_current_ref;
    end else if (i_voltage_ref_valid) begin
      source   = SRC_VOLTAGE;
      freq_sel = i_voltage_ref;
    end else begin
      source   = SRC_NONE;
      freq_sel = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // torque boost
  // ----------------------------------------------------------------
  logic [15:0] boost_base;
  logic [15:0] boost_out;

  assign boost_base = sel_second ? s.boost2 : s.boost;

  always_comb begin
    boost_out = boost_base;
    if (!flux_vector) begin
      case (pattern)
        PAT_LIFT_FWD: begin
          if (reverse) begin
            boost_out = 16'h0000;
          end
        end
        PAT_LIFT_REV: begin
          if (!reverse) begin
            boost_out = 16'h0000;
          end
        end
        default: begin
          boost_out = boost_base;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes with range checks
  // ----------------------------------------------------------------
  logic [7:0] preset_idx;
  logic [7:0] term_idx;
  logic       wr_ok_freq;
  logic       wr_ok_preset;
  logic [15:0] run_freq;

  assign preset_idx   = i_addr - ADDR_PRESET_BASE;
  assign term_idx     = i_addr - ADDR_TERM_BASE;
  assign wr_ok_freq   = (i_wdata <= FREQ_MAX);
  // the three basic presets have no unselected value
  assign wr_ok_preset = wr_ok_freq || (preset_idx > 8'(SLOT_LOW) && i_wdata == NOT_SELECTED);

  always_comb begin
    next_s = s;
    // writes carry no run or mode lock, so presets change on the fly
    if (i_wr) begin
      if (i_addr < ADDR_PRESET_BASE + 8'(NUM_PRESETS)) begin
        if (wr_ok_preset) begin
          next_s.preset[preset_idx[3:0]] = i_wdata;
        end
      end else if (i_addr >= ADDR_TERM_BASE && i_addr < ADDR_TERM_BASE + 8'(NUM_TERMS)) begin
        next_s.term_fn[term_idx[2:0]] = i_wdata[3:0];
      end else begin
        case (i_addr)
          ADDR_JOG_FREQ: begin
            if (wr_ok_freq) begin
              next_s.jog_freq = i_wdata;
            end
          end
          ADDR_JOG_RAMP: begin
            if (i_wdata <= RAMP_MAX) begin
              next_s.jog_ramp = i_wdata;
            end
          end
          ADDR_ACCEL_REF: begin
            if (wr_ok_freq) begin
              next_s.accel_ref = i_wdata;
            end
          end
          ADDR_BOOST: next_s.boost = i_wdata;
          ADDR_BOOST2: next_s.boost2 = i_wdata;
          ADDR_CONTROL: next_s.control = {8'h00, i_wdata[7:0]};
          default: next_s.control = s.control;
        endcase
      end
    end

    // read data stands only in the cycle after the strobe
    next_s.rdata = 16'h0000;
    if (i_rd) begin
      if (i_addr < ADDR_PRESET_BASE + 8'(NUM_PRESETS)) begin
        next_s.rdata = s.preset[preset_idx[3:0]];
      end else if (i_addr >= ADDR_TERM_BASE && i_addr < ADDR_TERM_BASE + 8'(NUM_TERMS)) begin
        next_s.rdata = {12'h000, s.term_fn[term_idx[2:0]]};
      end else begin
        case (i_addr)
          ADDR_JOG_FREQ: next_s.rdata = s.jog_freq;
          ADDR_JOG_RAMP: next_s.rdata = s.jog_ramp;
          ADDR_ACCEL_REF: next_s.rdata = s.accel_ref;
          ADDR_BOOST: next_s.rdata = s.boost;
          ADDR_BOOST2: next_s.rdata = s.boost2;
          ADDR_CONTROL: next_s.rdata = s.control;
          ADDR_STATUS: next_s.rdata = {3'b000, s.jog_mode, s.reverse, s.run, s.source, s.slot,
                                       sel_second, sel_extra, sel_jog};
          ADDR_FREQ_CMD: next_s.rdata = s.freq_cmd;
          ADDR_RUN_FREQ: next_s.rdata = run_freq;
          default: next_s.rdata = 16'h0000;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // registered outputs and ramp tick
    // ----------------------------------------------------------------
    next_s.source       = source;
    next_s.slot         = (source == SRC_PRESET) ? preset_slot : SLOT_NONE;
    next_s.run          = run;
    next_s.reverse      = reverse;
    next_s.jog_mode     = jog_mode;
    next_s.freq_cmd     = run ? freq_sel : 16'h0000;
    next_s.torque_boost = boost_out;
    next_s.tick         = (s.tick_cnt == 9'(TICK_CYCLES - 1));
    next_s.tick_cnt     = next_s.tick ? 9'h000 : s.tick_cnt + 9'h001;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s           <= '0;
      s.preset    <= {{(NUM_PRESETS-3){NOT_SELECTED}}, RST_LOW_FREQ, RST_MID_FREQ, RST_HIGH_FREQ};
      s.jog_freq  <= RST_JOG_FREQ;
      s.jog_ramp  <= RST_JOG_RAMP;
      s.accel_ref <= RST_ACCEL_REF;
      s.boost     <= RST_BOOST;
      s.boost2    <= RST_BOOST2;
      s.control   <= RST_CONTROL;
      s.term_fn   <= RST_TERM_FN;
      s.slot      <= SLOT_NONE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // ramp: jog ramp applies while in jog, other sources pass straight through
  // ----------------------------------------------------------------

  freq_ramp u_freq_ramp (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_tick      (s.tick),
    .i_target    (s.freq_cmd),
    .i_ramp_time (s.jog_mode ? s.jog_ramp : 16'h0000),
    .i_ref_freq  (s.accel_ref),
    .o_freq      (run_freq)
  );

  assign o_rdata        = s.rdata;
  assign o_freq_cmd     = s.freq_cmd;
  assign o_run_freq     = run_freq;
  assign o_source       = s.source;
  assign o_run          = s.run;
  assign o_reverse      = s.reverse;
  assign o_jog_mode     = s.jog_mode;
  assign o_torque_boost = s.torque_boost;

endmodule

// ---- testbench/speed_select_asserts.sv ----
// port checker for the speed command select block
module speed_select_asserts
  import speed_select_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] o_freq_cmd,
  input wire logic [15:0] o_run_freq,
  input wire logic [2:0]  o_source,
  input wire logic        o_run,
  input wire logic        o_jog_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_stop_cmd_zero:
  assert property (!o_run |-> o_freq_cmd == 16'h0000) else $error("command while stopped");
  a_jog_wins_src:
  assert property (o_jog_mode && o_run |-> o_source == SRC_JOG) else $error("jog not first");
  a_source_legal:
  assert property (o_source <= SRC_VOLTAGE) else $error("bad source code");
  a_none_cmd_zero:
  assert property (o_source == SRC_NONE |-> o_freq_cmd == 16'h0000) else $error("command without source");
  a_cmd_in_range:
  assert property (o_run |-> o_freq_cmd <= FREQ_MAX) else $error("command above range");
  a_run_follows_cmd:
  assert property (!o_jog_mode && !$past(o_jog_mode) |-> o_run_freq == $past(o_freq_cmd))
    else $error("run frequency not following");
  a_jog_ramp_slope:
  assert property (o_jog_mode && $past(o_jog_mode) |-> (o_run_freq - $past(o_run_freq) + 16'h0001) <= 16'h0002)
    else $error("jog ramp too steep");
  a_rdata_idle:
  assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data without read");
endmodule

bind contact_speed_command_select speed_select_asserts i_speed_select_asserts (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata), .o_freq_cmd(o_freq_cmd),
  .o_run_freq(o_run_freq), .o_source(o_source), .o_run(o_run), .o_jog_mode(o_jog_mode));

// ---- testbench/contact_model.sv ----
// contact switch model driving the select and start pins
module contact_model (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_sel,
  input  wire logic [1:0] i_start,
  output logic      [4:0] o_terminal,
  output logic            o_forward_start,
  output logic            o_reverse_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts switch on a clock edge, registered from the bench levels
  always_ff @(posedge i_clk) begin
    o_terminal      <= i_sel;
    o_forward_start <= i_start[0];
    o_reverse_start <= i_start[1];
  end
endmodule

// ---- testbench/contact_speed_command_select_tb_top.sv ----
// self-checking bench for the speed command select block
module contact_speed_command_select_tb_top
  import speed_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, fs, rs, cv, vv, run, rev, jogm, pj, pr, pv;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, fcmd, rfreq, boost, cref, vref;
  logic [4:0]  sel, term;
  logic [1:0]  start;
  logic [2:0]  src;
  int          error_cnt, samples_checked, cyc;
  logic [7:0]  ra [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h1b, 8'h30};
  logic [15:0] rv [9] = '{16'h01f4, 16'h012c, 16'h0064, 16'h270f, 16'h0032, 16'h0005, 16'h01f4, 16'h0005, 16'h0000};
  logic [4:0]  pc [6] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h07, 5'h10};
  logic [15:0] pf [6] = '{16'h0064, 16'h012c, 16'h01f4, 16'h012c, 16'h0064, 16'h0064};

  contact_model i_contact_model (.i_clk(clk), .i_sel(sel), .i_start(start), .o_terminal(term),
    .o_forward_start(fs), .o_reverse_start(rs));
  // panel levels are same-clock inputs, so the bench drives them directly
  contact_speed_command_select i_contact_speed_command_select (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_terminal(term), .i_forward_start(fs),
    .i_reverse_start(rs), .i_panel_jog_mode(pj), .i_panel_run(pr), .i_panel_reverse(pv),
    .i_current_ref_valid(cv), .i_current_ref(cref), .i_voltage_ref_valid(vv), .i_voltage_ref(vref),
    .o_freq_cmd(fcmd), .o_run_freq(rfreq), .o_source(src), .o_run(run), .o_reverse(rev),
    .o_jog_mode(jogm), .o_torque_boost(boost));

  // ----------------------------------------------------------------
  // bus, pin and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  // partner edge, four sync edges and one output edge, plus margin for the run frequency
  task automatic pins(input logic [4:0] s, input logic [1:0] st);
    {sel, start} <= {s, st};
    repeat (7) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    wreg(8'h00, 16'h0fa1);
    rchk(8'h00, 16'h01f4);
  endtask
  task automatic t_presets;
    for (int i = 0; i < 6; i++) begin
      pins(pc[i], 2'b01);
      chk(fcmd, pf[i]);
      chk({13'h0, src}, {13'h0, SRC_PRESET});
    end
    wreg(8'h07, 16'h0123);
    pins(5'h10, 2'b01);
    chk(fcmd, 16'h0123);
    pins(5'h00, 2'b00);
    chk({15'h0, run}, 16'h0000);
  endtask
  task automatic t_jog;
    pins(5'h09, 2'b10);
    chk(fcmd, 16'h0032);
    chk({13'h0, jogm, rev, run}, 16'h0007);
    pins(5'h09, 2'b00);
    chk({15'h0, run}, 16'h0000);
    wreg(ADDR_CONTROL, 16'h0004);
    {pj, pr, pv} <= 3'b111;
    pins(5'h00, 2'b00);
    chk(fcmd, 16'h0032);
    chk({13'h0, jogm, rev, run}, 16'h0007);
    {pj, pr, pv} <= 3'b000;
    wreg(ADDR_CONTROL, 16'h0008);
  endtask
  task automatic t_sources;
    {cv, cref, vv, vref} <= {1'b1, 16'h0100, 1'b1, 16'h0200};
    wreg(ADDR_CONTROL, 16'h0010);
    pins(5'h01, 2'b01);
    chk({13'h0, src}, {13'h0, SRC_PRESET});
    wreg(ADDR_CONTROL, 16'h0004);
    pins(5'h01, 2'b01);
    chk({13'h0, src}, {13'h0, SRC_CURRENT});
    wreg(ADDR_CONTROL, 16'h0028);
    pins(5'h01, 2'b01);
    chk({13'h0, src}, {13'h0, SRC_CURRENT});
    wreg(ADDR_CONTROL, 16'h0008);
    pins(5'h00, 2'b01);
    chk(fcmd, 16'h0100);
    chk(rfreq, 16'h0100);
    rchk(ADDR_FREQ_CMD, 16'h0100);
    cv <= 1'b0;
    pins(5'h00, 2'b01);
    chk(fcmd, 16'h0200);
    vv <= 1'b0;
  endtask
  task automatic t_boost;
    wreg(ADDR_CONTROL, 16'h000a);
    pins(5'h01, 2'b01);
    chk(boost, 16'h003c);
    pins(5'h01, 2'b10);
    chk(boost, 16'h0000);
    wreg(ADDR_CONTROL, 16'h008a);
    pins(5'h01, 2'b10);
    chk(boost, 16'h003c);
    wreg(ADDR_CONTROL, 16'h000b);
    pins(5'h01, 2'b01);
    chk(boost, 16'h0000);
    wreg(ADDR_CONTROL, 16'h000a);
    wreg(8'h1c, 16'h0003);
    wreg(ADDR_BOOST2, 16'h0050);
    pins(5'h11, 2'b01);
    chk(boost, 16'h0050);
    wreg(8'h18, 16'h0002);
    pins(5'h01, 2'b01);
    chk(fcmd, 16'h01f4);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {rst, wr, rd, addr, wdata, sel, start, cv, cref, vv, vref, pj, pr, pv} = {1'b1, 70'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_presets();
    t_jog();
    t_sources();
    t_boost();
    finish_test();
  end
endmodule
